// [rtl/ofd_map.svh]
/*
 * Field codes, fixed address pages and bit positions of the operand
 * field decoder. Assumes inclusion by bare name from the rtl folder.
 */
// Operation
// - Three-bit register code: X, A, C, B, E, D, L, H in order.
// - Register byte: upper nibble is first operand, lower nibble second.
// - Pair code 00 AX, 01 BC, 10 DE, 11 HL; counter bit C or B.
// - Memory mode 10110 indirect, 00110 base, 01010 word indexed.
// - Selector meaning depends on mode: indirect, base and indexed tables.
// - Restricted memory operand: one opcode bit, 0 is DE, 1 is HL.
// - Relative offset is signed byte added to next instruction address.
// - Short call field carries the low 11 target address bits.
// - Table call field carries low 5 bits of entry index times spacing.
// - Short direct byte is the low byte of a 16-bit address.
// - Special register byte is the low byte of its 16-bit address.
// - Indexed offset is 16 bits, low byte first, with index register.
// - Absolute address is 16 bits, low byte first then high.
// - Each branch and call family accepts only its listed target forms.
// - Every conditional branch uses the relative form like carry-set.
// - DE or HL indirect forms also accept the compact encoding.
`ifndef OFD_MAP_SVH
`define OFD_MAP_SVH

// Memory addressing-mode codes
`define OFD_MOD_INDIRECT 5'h16
`define OFD_MOD_BASE     5'h06
`define OFD_MOD_INDEXED  5'h0A

// Selector codes
`define OFD_SEL_0 3'h0
`define OFD_SEL_1 3'h1
`define OFD_SEL_2 3'h2
`define OFD_SEL_3 3'h3
`define OFD_SEL_4 3'h4
`define OFD_SEL_5 3'h5

// Fixed pages and table base; plain defaults
`define OFD_SADDR_PAGE 8'hFE
`define OFD_SFR_PAGE   8'hFF
`define OFD_TABLE_BASE 16'h0040

// Field positions in the code bytes, and a reset value
`define OFD_REG_LSB    0
`define OFD_NIB_HI_LSB 4
`define OFD_NIB_LO_LSB 0
`define OFD_PAIR_LSB   1
`define OFD_SEL_LSB    4
`define OFD_RST_VALUE  16'h0000

`endif

// [rtl/ofd_pkg.sv]
/*
 * Types of the operand field decoder: register names, request forms,
 * branch families and memory operand descriptions.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ofd_pkg;

	typedef enum logic [2:0] {
		REG_IDX, REG_A, REG_C, REG_B, REG_E, REG_D, REG_L, REG_H
	} ofd_reg_t;

	typedef enum logic [1:0] {
		PAIR_AX, PAIR_BC, PAIR_DE, PAIR_HL
	} ofd_pair_t;

	typedef enum logic [3:0] {
		FORM_NONE, FORM_REG, FORM_REG_BYTE, FORM_PAIR, FORM_PAIR_BYTE,
		FORM_CNT, FORM_MEM, FORM_MEM_COMPACT, FORM_MEM_RESTRICT,
		FORM_REL, FORM_ABS, FORM_PAIR_TGT, FORM_SHORT_CALL,
		FORM_TABLE_CALL, FORM_SADDR, FORM_SFR
	} ofd_form_t;

	typedef enum logic [2:0] {
		FAM_NONE, FAM_BR, FAM_BCOND, FAM_CALL, FAM_FIXED_CALL,
		FAM_TABLE_CALL, FAM_BIT_TEST, FAM_DEC_BRANCH
	} ofd_family_t;

	typedef enum logic [1:0] {
		MODE_NONE, MODE_INDIRECT, MODE_BASE, MODE_INDEXED
	} ofd_mode_t;

	typedef enum logic [2:0] {
		PTR_NONE, PTR_DE, PTR_HL, PTR_SP, PTR_A, PTR_B
	} ofd_ptr_t;

	typedef enum logic [1:0] {
		STEP_NONE, STEP_INC, STEP_DEC
	} ofd_step_t;

	typedef struct packed {
		logic        valid;
		logic        undef;
		logic        mem_access;
		ofd_reg_t    reg_first;
		ofd_reg_t    reg_second;
		ofd_pair_t   pair_first;
		ofd_pair_t   pair_second;
		ofd_reg_t    cnt_reg;
		ofd_mode_t   mem_mode;
		ofd_ptr_t    mem_base;
		ofd_step_t   mem_step;
		logic [15:0] mem_disp;
		logic [15:0] tgt_addr;
		logic        tgt_valid;
	} ofd_state_t;

endpackage

// [rtl/ofd_mem_sel.sv]
/*
 * Memory operand selector decode: turns a mode code and selector into
 * a mode, pointer and step, or an undefined flag.
 * Assumes the caller registers the result; purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ofd_map.svh"

module ofd_mem_sel
	import ofd_pkg::*;
(
	input  wire logic [4:0] mode_code,   // Addressing-mode field
	input  wire logic [2:0] sel_code,    // Selector field
	output ofd_mode_t       mode,        // Decoded mode
	output ofd_ptr_t        ptr,         // Pointer register
	output ofd_step_t       step,        // Post step
	output logic            undef        // Unlisted combination
);

	// Selector meaning depends on mode; anything unlisted is undefined
	always_comb begin
		mode  = MODE_NONE;
		ptr   = PTR_NONE;
		step  = STEP_NONE;
		undef = 1'b0;
		if (mode_code == `OFD_MOD_INDIRECT) begin
			mode = MODE_INDIRECT;
			case (sel_code)
				`OFD_SEL_0: begin ptr = PTR_DE; step = STEP_INC; end
				`OFD_SEL_1: begin ptr = PTR_HL; step = STEP_INC; end
				`OFD_SEL_2: begin ptr = PTR_DE; step = STEP_DEC; end
				`OFD_SEL_3: begin ptr = PTR_HL; step = STEP_DEC; end
				`OFD_SEL_4: ptr = PTR_DE;
				`OFD_SEL_5: ptr = PTR_HL;
				default: undef = 1'b1;
			endcase
		end else if (mode_code == `OFD_MOD_BASE) begin
			mode = MODE_BASE;
			case (sel_code)
				`OFD_SEL_0: ptr = PTR_DE;
				`OFD_SEL_1: ptr = PTR_SP;
				`OFD_SEL_2: ptr = PTR_HL;
				default: undef = 1'b1;
			endcase
		end else if (mode_code == `OFD_MOD_INDEXED) begin
			mode = MODE_INDEXED;
			case (sel_code)
				`OFD_SEL_0: ptr = PTR_DE;
				`OFD_SEL_1: ptr = PTR_A;
				`OFD_SEL_2: ptr = PTR_HL;
				`OFD_SEL_3: ptr = PTR_B;
				default: undef = 1'b1;
			endcase
		end else begin
			undef = 1'b1;
		end
	end

endmodule

`default_nettype wire

// [rtl/ofd_decoder.sv]
/*
 * Operand field decoder: one request per instruction from the fetch
 * unit, decoded operand description one cycle later for execution.
 * Assumes the fetch unit presents all operand bytes of the instruction
 * together with the request, and the address of the next instruction.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ofd_map.svh"

module ofd_decoder
	import ofd_pkg::*;
(
	input  wire logic        core_clk,     // Core clock, 100 MHz
	input  wire logic        nrst,         // Async reset, active low
	input  wire logic        dec_req,      // Request strobe
	input  wire ofd_form_t   req_form,     // Operand form to decode
	input  wire ofd_family_t req_family,   // Branch or call family
	input  wire logic [7:0]  op_code,      // First code byte
	input  wire logic [7:0]  op_ext,       // Second code byte
	input  wire logic [7:0]  op_lo,        // First operand byte
	input  wire logic [7:0]  op_hi,        // Second operand byte
	input  wire logic [15:0] next_pc,      // Start of next instruction
	output logic             dec_valid,    // Result valid pulse
	output logic             dec_undef,    // Undefined instruction
	output logic             mem_access,   // Memory access needed
	output ofd_reg_t         reg_first,    // First register
	output ofd_reg_t         reg_second,   // Second register
	output ofd_pair_t        pair_first,   // First pair
	output ofd_pair_t        pair_second,  // Second pair
	output ofd_reg_t         cnt_reg,      // Counter register
	output ofd_mode_t        mem_mode,     // Memory mode
	output ofd_ptr_t         mem_base,     // Pointer register
	output ofd_step_t        mem_step,     // Post step
	output logic [15:0]      mem_disp,     // Offset for base/index
	output logic [15:0]      tgt_addr,     // Target or direct address
	output logic             tgt_valid     // Target address valid
);

	ofd_state_t st;
	ofd_state_t next_st;

	logic       is_compact;
	logic [4:0] sel_mode;
	logic [2:0] sel_sel;
	ofd_mode_t  ms_mode;
	ofd_ptr_t   ms_ptr;
	ofd_step_t  ms_step;
	logic       ms_undef;

	// Which targets each family may use
	function automatic logic form_allowed(ofd_family_t fam, ofd_form_t f);
		logic ok;
		ok = 1'b0;
		case (fam)
			FAM_NONE:       ok = 1'b1;
			FAM_BR:         ok = (f == FORM_REL) || (f == FORM_ABS) ||
					     (f == FORM_PAIR_TGT);
			FAM_BCOND:      ok = (f == FORM_REL);
			FAM_CALL:       ok = (f == FORM_ABS) || (f == FORM_PAIR_TGT);
			FAM_FIXED_CALL: ok = (f == FORM_SHORT_CALL);
			FAM_TABLE_CALL: ok = (f == FORM_TABLE_CALL);
			FAM_BIT_TEST:   ok = (f == FORM_REL);
			FAM_DEC_BRANCH: ok = (f == FORM_REL);
			default:        ok = 1'b0;
		endcase
		return ok;
	endfunction

	// Compact form carries the selector in the code byte itself
	assign is_compact = (req_form == FORM_MEM_COMPACT);
	assign sel_mode   = is_compact ? `OFD_MOD_INDIRECT : op_code[4:0];
	assign sel_sel    = is_compact ? op_code[2:0] : op_ext[6:4];

	ofd_mem_sel u_mem_sel (
		.mode_code (sel_mode),
		.sel_code  (sel_sel),
		.mode      (ms_mode),
		.ptr       (ms_ptr),
		.step      (ms_step),
		.undef     (ms_undef)
	);

	// Decode the requested form; outputs clear when no request
	always_comb begin
		next_st       = '0;
		next_st.valid = dec_req;
		if (dec_req) begin
			case (req_form)
				FORM_REG: begin
					next_st.reg_first = ofd_reg_t'(op_code[2:0]);
				end
				FORM_REG_BYTE: begin
					// Nibble top bits must be zero, else code is unlisted
					next_st.reg_first  = ofd_reg_t'(op_ext[6:4]);
					next_st.reg_second = ofd_reg_t'(op_ext[2:0]);
					next_st.undef      = op_ext[7] | op_ext[3];
				end
				FORM_PAIR: begin
					next_st.pair_first = ofd_pair_t'(op_code[1:0]);
				end
				FORM_PAIR_BYTE: begin
					next_st.pair_first  = ofd_pair_t'(op_ext[6:5]);
					next_st.pair_second = ofd_pair_t'(op_ext[2:1]);
					next_st.undef       = op_ext[7] | op_ext[3] |
							      op_ext[4] | op_ext[0];
				end
				FORM_CNT: begin
					next_st.cnt_reg = op_code[0] ? REG_B : REG_C;
				end
				FORM_MEM, FORM_MEM_COMPACT: begin
					next_st.mem_mode = ms_mode;
					next_st.mem_base = ms_ptr;
					next_st.mem_step = ms_step;
					next_st.undef    = ms_undef;
					if (ms_mode == MODE_BASE && !is_compact) begin
						next_st.mem_disp = {8'h00, op_lo};
					end else if (ms_mode == MODE_INDEXED && !is_compact) begin
						next_st.mem_disp = {op_hi, op_lo};
					end
					next_st.mem_access = !ms_undef;
				end
				FORM_MEM_RESTRICT: begin
					next_st.mem_mode   = MODE_INDIRECT;
					next_st.mem_base   = op_code[0] ? PTR_HL : PTR_DE;
					next_st.mem_access = 1'b1;
				end
				FORM_REL: begin
					next_st.tgt_addr  = 16'(next_pc +
							    {{8{op_lo[7]}}, op_lo});
					next_st.tgt_valid = 1'b1;
				end
				FORM_ABS: begin
					next_st.tgt_addr  = {op_hi, op_lo};
					next_st.tgt_valid = 1'b1;
				end
				FORM_PAIR_TGT: begin
					// Target comes from the pair at execution time
					next_st.pair_first = ofd_pair_t'(op_code[1:0]);
				end
				FORM_SHORT_CALL: begin
					next_st.tgt_addr  = {5'h00, op_code[2:0], op_lo};
					next_st.tgt_valid = 1'b1;
				end
				FORM_TABLE_CALL: begin
					next_st.tgt_addr  = 16'(`OFD_TABLE_BASE +
							    {11'h000, op_code[4:0]});
					next_st.tgt_valid = 1'b1;
				end
				FORM_SADDR: begin
					next_st.tgt_addr  = {`OFD_SADDR_PAGE, op_lo};
					next_st.tgt_valid = 1'b1;
				end
				FORM_SFR: begin
					next_st.tgt_addr  = {`OFD_SFR_PAGE, op_lo};
					next_st.tgt_valid = 1'b1;
				end
				default: begin
					next_st.undef = 1'b1;
				end
			endcase
			// A family given a foreign target form is rejected whole
			if (!form_allowed(req_family, req_form)) begin
				next_st.undef = 1'b1;
			end
			// No access and no target ever leave with an undefined code
			if (next_st.undef) begin
				next_st.mem_access = 1'b0;
				next_st.tgt_valid  = 1'b0;
			end
		end
	end

	// Single result register
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the result register
	assign dec_valid   = st.valid;
	assign dec_undef   = st.undef;
	assign mem_access  = st.mem_access;
	assign reg_first   = st.reg_first;
	assign reg_second  = st.reg_second;
	assign pair_first  = st.pair_first;
	assign pair_second = st.pair_second;
	assign cnt_reg     = st.cnt_reg;
	assign mem_mode    = st.mem_mode;
	assign mem_base    = st.mem_base;
	assign mem_step    = st.mem_step;
	assign mem_disp    = st.mem_disp;
	assign tgt_addr    = st.tgt_addr;
	assign tgt_valid   = st.tgt_valid;

	// Checks on the registered result
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_reg_single: assert property (
		dec_req && req_form == FORM_REG && req_family == FAM_NONE |=>
		dec_valid && reg_first == ofd_reg_t'(3'($past(op_code))))
		else $error("single register code decoded wrong");

	a_reg_byte_split: assert property (
		dec_req && req_form == FORM_REG_BYTE && req_family == FAM_NONE |=>
		reg_first == ofd_reg_t'(3'($past(op_ext) >> 4)) &&
		reg_second == ofd_reg_t'(3'($past(op_ext))))
		else $error("register byte nibbles swapped or wrong");

	a_cnt_pair: assert property (
		dec_req && req_form == FORM_CNT && req_family == FAM_NONE |=>
		cnt_reg == ((($past(op_code) & 8'h01) != 8'h00) ? REG_B : REG_C))
		else $error("counter register bit decoded wrong");

	a_mem_hl_inc: assert property (
		dec_req && req_form == FORM_MEM && req_family == FAM_NONE &&
		op_code[4:0] == `OFD_MOD_INDIRECT && op_ext[6:4] == `OFD_SEL_1 |=>
		mem_mode == MODE_INDIRECT && mem_base == PTR_HL &&
		mem_step == STEP_INC && mem_access && !dec_undef)
		else $error("indirect HL post-increment not decoded");

	a_mem_restrict: assert property (
		dec_req && req_form == FORM_MEM_RESTRICT && req_family == FAM_NONE |=>
		mem_access && mem_base ==
		((($past(op_code) & 8'h01) != 8'h00) ? PTR_HL : PTR_DE))
		else $error("restricted memory operand pointer wrong");

	a_rel_target: assert property (
		dec_req && req_form == FORM_REL && req_family == FAM_BCOND |=>
		tgt_valid && !dec_undef && tgt_addr ==
		16'($past(next_pc) + 16'(signed'($past(op_lo)))))
		else $error("relative target sum wrong");

	a_abs_order: assert property (
		dec_req && req_form == FORM_ABS && req_family == FAM_CALL |=>
		tgt_valid && tgt_addr == {$past(op_hi), $past(op_lo)})
		else $error("absolute address byte order wrong");

	a_sfr_page: assert property (
		dec_req && req_form == FORM_SFR && req_family == FAM_NONE |=>
		tgt_addr == {`OFD_SFR_PAGE, $past(op_lo)})
		else $error("special register address wrong");

	a_family_reject: assert property (
		dec_req && req_family == FAM_CALL && req_form == FORM_REL |=>
		dec_undef && !tgt_valid && !mem_access)
		else $error("call accepted a relative target");

	a_reg_pair: assert property (
		dec_req && req_form == FORM_PAIR && req_family == FAM_NONE |=>
		pair_first == ofd_pair_t'(2'($past(op_code))))
		else $error("register pair code decoded wrong");

	a_pair_byte_split: assert property (
		dec_req && req_form == FORM_PAIR_BYTE && req_family == FAM_NONE |=>
		pair_first == ofd_pair_t'(2'($past(op_ext) >> 5)) &&
		pair_second == ofd_pair_t'(2'($past(op_ext) >> 1)))
		else $error("pair byte nibbles swapped or wrong");

	a_mem_base_disp: assert property (
		dec_req && req_form == FORM_MEM && req_family == FAM_NONE &&
		op_code[4:0] == `OFD_MOD_BASE && op_ext[6:4] == `OFD_SEL_1 |=>
		mem_mode == MODE_BASE && mem_base == PTR_SP && mem_access &&
		mem_disp == {8'h00, $past(op_lo)})
		else $error("base mode offset or pointer wrong");

	a_mem_index_disp: assert property (
		dec_req && req_form == FORM_MEM && req_family == FAM_NONE &&
		op_code[4:0] == `OFD_MOD_INDEXED && op_ext[6:4] == `OFD_SEL_1 |=>
		mem_mode == MODE_INDEXED && mem_base == PTR_A && mem_access &&
		mem_disp == {$past(op_hi), $past(op_lo)})
		else $error("indexed offset or pointer wrong");

	a_mem_compact: assert property (
		dec_req && req_form == FORM_MEM_COMPACT && req_family == FAM_NONE &&
		op_code[2:0] == `OFD_SEL_2 |=>
		mem_mode == MODE_INDIRECT && mem_base == PTR_DE &&
		mem_step == STEP_DEC && mem_access && !dec_undef)
		else $error("compact indirect form not decoded");

	a_mem_bad_mode: assert property (
		dec_req && req_form == FORM_MEM && op_code[4:0] != `OFD_MOD_INDIRECT &&
		op_code[4:0] != `OFD_MOD_BASE && op_code[4:0] != `OFD_MOD_INDEXED |=>
		dec_undef && !mem_access)
		else $error("unlisted memory mode not rejected");

	a_short_call: assert property (
		dec_req && req_form == FORM_SHORT_CALL &&
		req_family == FAM_FIXED_CALL |=>
		tgt_valid && tgt_addr == {5'h00, 3'($past(op_code)), $past(op_lo)})
		else $error("short call address wrong");

	a_table_call: assert property (
		dec_req && req_form == FORM_TABLE_CALL &&
		req_family == FAM_TABLE_CALL |=>
		tgt_valid && tgt_addr ==
		16'(`OFD_TABLE_BASE + {11'h000, 5'($past(op_code))}))
		else $error("table call entry address wrong");

	a_saddr_page: assert property (
		dec_req && req_form == FORM_SADDR && req_family == FAM_NONE |=>
		tgt_valid && tgt_addr == {`OFD_SADDR_PAGE, $past(op_lo)})
		else $error("short direct address wrong");

	a_cond_relative: assert property (
		dec_req && req_family == FAM_BCOND && req_form != FORM_REL |=>
		dec_undef && !tgt_valid)
		else $error("conditional branch took a non-relative target");

	a_undef_no_access: assert property (
		dec_undef |-> !mem_access && !tgt_valid)
		else $error("undefined code still accesses memory");

endmodule

`default_nettype wire

// [verification/ofd_fetch_model.sv]
/*
 * Fetch unit model: presents one instruction's operand bytes per call.
 * Assumes the decoder takes the request on the rising core_clk edge.
 */
`timescale 1ns/100ps
`default_nettype none

module ofd_fetch_model
	import ofd_pkg::*;
(
	input  wire logic       core_clk,   // Core clock
	output var logic        dec_req,    // Request strobe
	output var ofd_form_t   req_form,   // Operand form
	output var ofd_family_t req_family, // Branch or call family
	output var logic [7:0]  op_code,    // First code byte
	output var logic [7:0]  op_ext,     // Second code byte
	output var logic [7:0]  op_lo,      // Low operand byte
	output var logic [7:0]  op_hi,      // High operand byte
	output var logic [15:0] next_pc     // Next instruction start
);
	// Quiet lines until the first request
	initial begin
		dec_req = 1'b0;
		req_form = FORM_NONE;
		req_family = FAM_NONE;
		op_code = 8'h00;
		op_ext = 8'h00;
		op_lo = 8'h00;
		op_hi = 8'h00;
		next_pc = 16'h0000;
	end

	// One request cycle; bytes go stale after the taking edge
	task automatic send(input ofd_form_t f, input ofd_family_t fam,
		input logic [7:0] c, input logic [7:0] e,
		input logic [15:0] w, input logic [15:0] pc);
		@(posedge core_clk);
		#1;
		dec_req = 1'b1;
		req_form = f;
		req_family = fam;
		op_code = c;
		op_ext = e;
		op_lo = w[7:0];   // Low byte first
		op_hi = w[15:8];
		next_pc = pc;
		@(posedge core_clk);
		#1;
		dec_req = 1'b0;
		// Inverted so a late sample of stale bytes cannot match
		op_code = ~op_code;
		op_ext = ~op_ext;
		op_lo = ~op_lo;
		op_hi = ~op_hi;
		next_pc = ~next_pc;
	endtask
endmodule

`default_nettype wire

// [verification/ofd_decoder_tb.sv]
/*
 * Self-checking bench of the operand field decoder, one task a scenario.
 * Assumes the fetch model drives every decoder input except core_clk and nrst, which the bench drives.
 */
`timescale 1ns/100ps
`default_nettype none

module ofd_decoder_tb
	import ofd_pkg::*;
;

	logic        core_clk, nrst, dec_req, dec_valid, dec_undef;
	logic        mem_access, tgt_valid;
	ofd_form_t   req_form;
	ofd_family_t req_family;
	logic [7:0]  op_code, op_ext, op_lo, op_hi;
	logic [15:0] next_pc, mem_disp, tgt_addr;
	ofd_reg_t    reg_first, reg_second, cnt_reg;
	ofd_pair_t   pair_first, pair_second;
	ofd_mode_t   mem_mode;
	ofd_ptr_t    mem_base;
	ofd_step_t   mem_step;
	int          failures = 0;
	int          num_checks = 0;
	int          cycles = 0;

	ofd_fetch_model u_fetch (.core_clk(core_clk), .dec_req(dec_req),
		.req_form(req_form), .req_family(req_family), .op_code(op_code),
		.op_ext(op_ext), .op_lo(op_lo), .op_hi(op_hi), .next_pc(next_pc));

	ofd_decoder uut (.core_clk(core_clk), .nrst(nrst), .dec_req(dec_req),
		.req_form(req_form), .req_family(req_family), .op_code(op_code),
		.op_ext(op_ext), .op_lo(op_lo), .op_hi(op_hi), .next_pc(next_pc),
		.dec_valid(dec_valid), .dec_undef(dec_undef),
		.mem_access(mem_access), .reg_first(reg_first),
		.reg_second(reg_second), .pair_first(pair_first),
		.pair_second(pair_second), .cnt_reg(cnt_reg), .mem_mode(mem_mode),
		.mem_base(mem_base), .mem_step(mem_step), .mem_disp(mem_disp),
		.tgt_addr(tgt_addr), .tgt_valid(tgt_valid));

	// Free-running 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Hang guard, well above the roughly 190 cycles the tests need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			$display("[ERR] %0t timeout", $time);
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One decode; returns in the answer cycle
	task automatic dec(input ofd_form_t f, input ofd_family_t fam,
		input logic [7:0] c, input logic [7:0] e,
		input logic [15:0] w, input logic [15:0] pc);
		u_fetch.send(f, fam, c, e, w, pc);
		chk(dec_valid, 1'b1, "valid");
	endtask

	task automatic t_regs();
		ofd_reg_t  rn [8] = '{REG_IDX, REG_A, REG_C, REG_B,
			REG_E, REG_D, REG_L, REG_H};
		ofd_pair_t rp [4] = '{PAIR_AX, PAIR_BC, PAIR_DE, PAIR_HL};
		// Unused code bits set high to catch sloppy field slicing
		for (int i = 0; i < 8; i++) begin
			dec(FORM_REG, FAM_NONE, {5'h1F, 3'(i)}, 8'h00, 16'h0, 16'h0);
			chk(reg_first, rn[i], "reg");
		end
		for (int i = 0; i < 4; i++) begin
			dec(FORM_PAIR, FAM_NONE, {6'h3F, 2'(i)}, 8'h00, 16'h0, 16'h0);
			chk(pair_first, rp[i], "pair");
		end
		for (int i = 0; i < 2; i++) begin
			dec(FORM_CNT, FAM_NONE, {7'h7F, 1'(i)}, 8'h00, 16'h0, 16'h0);
			chk(cnt_reg, i ? REG_B : REG_C, "cnt");
			dec(FORM_MEM_RESTRICT, FAM_NONE, {7'h7F, 1'(i)}, 8'h0, 16'h0,
				16'h0);
			chk(mem_base, i ? PTR_HL : PTR_DE, "restr");
			chk(mem_access, 1'b1, "restr acc");
		end
		dec(FORM_REG_BYTE, FAM_NONE, 8'h00, 8'h16, 16'h0, 16'h0);
		chk(reg_first, REG_A, "first");
		chk(reg_second, REG_L, "second");
		chk(dec_undef, 1'b0, "byte ok");
		// Spare nibble bits set: the byte names no register
		dec(FORM_REG_BYTE, FAM_NONE, 8'h00, 8'h9E, 16'h0, 16'h0);
		chk(dec_undef, 1'b1, "byte bad");
		dec(FORM_PAIR_BYTE, FAM_NONE, 8'h00, 8'h62, 16'h0, 16'h0);
		chk(pair_first, PAIR_HL, "pfirst");
		chk(pair_second, PAIR_BC, "psecond");
		chk(dec_undef, 1'b0, "pbyte ok");
	endtask

	task automatic mem_one(input logic [7:0] c, input logic [7:0] e,
		input ofd_form_t f, input ofd_mode_t em, input ofd_ptr_t ep,
		input ofd_step_t es, input logic u);
		dec(f, FAM_NONE, c, e, 16'hA55A, 16'h0);
		chk(dec_undef, u, "undef");
		chk(mem_access, !u, "access");
		if (!u) begin
			chk(mem_mode, em, "mode");
			chk(mem_base, ep, "base");
			chk(mem_step, es, "step");
			chk(mem_disp, em == MODE_INDEXED ? 16'hA55A :
				(em == MODE_BASE ? 16'h005A : 16'h0000), "disp");
		end
	endtask

	task automatic t_mem();
		ofd_ptr_t  ip [6] = '{PTR_DE, PTR_HL, PTR_DE, PTR_HL, PTR_DE, PTR_HL};
		ofd_step_t is [6] = '{STEP_INC, STEP_INC, STEP_DEC, STEP_DEC,
			STEP_NONE, STEP_NONE};
		ofd_ptr_t  bp [3] = '{PTR_DE, PTR_SP, PTR_HL};
		ofd_ptr_t  xp [4] = '{PTR_DE, PTR_A, PTR_HL, PTR_B};
		// Each mode walks past its last defined code: indirect by two selectors, base and indexed by one
		for (int i = 0; i < 8; i++) begin
			mem_one(8'h16, {1'b0, 3'(i), 4'h0}, FORM_MEM, MODE_INDIRECT,
				ip[i % 6], is[i % 6], i > 5);
			mem_one({5'h00, 3'(i)}, 8'h00, FORM_MEM_COMPACT, MODE_INDIRECT,
				ip[i % 6], is[i % 6], i > 5);
		end
		for (int i = 0; i < 4; i++) begin
			mem_one(8'h06, {1'b0, 3'(i), 4'h0}, FORM_MEM, MODE_BASE,
				bp[i % 3], STEP_NONE, i == 3);
		end
		for (int i = 0; i < 5; i++) begin
			mem_one(8'h0A, {1'b0, 3'(i), 4'h0}, FORM_MEM, MODE_INDEXED,
				xp[i % 4], STEP_NONE, i == 4);
		end
		mem_one(8'h17, 8'h00, FORM_MEM, MODE_NONE, PTR_NONE, STEP_NONE,
			1'b1);
	endtask

	task automatic t_targets();
		dec(FORM_REL, FAM_BR, 8'h00, 8'h00, 16'h0080, 16'h1000);
		chk(tgt_addr, 16'h0F80, "rel back");
		chk(tgt_valid, 1'b1, "rel valid");
		dec(FORM_REL, FAM_BR, 8'h00, 8'h00, 16'h007F, 16'hFFF0);
		chk(tgt_addr, 16'h006F, "rel wrap");
		dec(FORM_ABS, FAM_CALL, 8'h00, 8'h00, 16'h1234, 16'h0);
		chk(tgt_addr, 16'h1234, "abs");
		dec(FORM_SHORT_CALL, FAM_FIXED_CALL, 8'hFD, 8'h00, 16'h00A5, 16'h0);
		chk(tgt_addr, 16'h05A5, "short call");
		dec(FORM_TABLE_CALL, FAM_TABLE_CALL, 8'hFE, 8'h00, 16'h0, 16'h0);
		chk(tgt_addr, 16'h005E, "table call");
		dec(FORM_SADDR, FAM_NONE, 8'h00, 8'h00, 16'hFF3C, 16'h0);
		chk(tgt_addr, 16'hFE3C, "short direct");
		dec(FORM_SFR, FAM_NONE, 8'h00, 8'h00, 16'h00C1, 16'h0);
		chk(tgt_addr, 16'hFFC1, "special reg");
		// Answer stands one cycle only
		@(posedge core_clk);
		#1;
		chk(dec_valid, 1'b0, "pulse");
		chk(tgt_addr, 16'h0000, "cleared");
	endtask

	task automatic t_family();
		ofd_form_t  fm [5] = '{FORM_REL, FORM_ABS, FORM_PAIR_TGT,
			FORM_SHORT_CALL, FORM_TABLE_CALL};
		logic [4:0] ok [8] = '{5'h1F, 5'h07, 5'h01, 5'h06,
			5'h08, 5'h10, 5'h01, 5'h01};
		// Every family against every target form
		for (int f = 0; f < 8; f++) begin
			for (int j = 0; j < 5; j++) begin
				dec(fm[j], ofd_family_t'(f), 8'h00, 8'h00, 16'h1234, 16'h2000);
				chk(dec_undef, !ok[f][j], "family");
			end
		end
	endtask

	// Reset, then the scenarios in turn
	initial begin
		nrst = 1'b0;
		repeat (5) @(posedge core_clk);
		#1;
		nrst = 1'b1;
		chk(dec_valid, 1'b0, "idle");
		t_regs();
		t_mem();
		t_targets();
		t_family();
		test_done();
	end
endmodule

`default_nettype wire
